// file: hw/ppcm_pkg.sv
// Purpose: Shared constants for the control-pin logic block
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register bus
// Notes: Byte offsets are word aligned; narrow registers sit in the low bits
package ppcm_pkg;
    localparam int N_EN = 6;
    localparam int N_RAIL = 8;
    localparam int N_GPO = 4;
    localparam int VSEL_W = 8;
    localparam int ADR_W = 8;

    // Clock and debounce timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEB_TIME_NS = 1000;
    localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CNT_W = $clog2(DEB_CYCLES + 1);

    // Register byte offsets
    localparam logic [7:0] OFS_ENMAP0 = 8'h00;
    localparam logic [7:0] OFS_ENMAP5 = 8'h14;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h18;
    localparam logic [7:0] OFS_GPO_CFG = 8'h1c;
    localparam logic [7:0] OFS_GPO_PGMASK0 = 8'h20;
    localparam logic [7:0] OFS_GPO_PGMASK3 = 8'h2c;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    localparam logic [7:0] OFS_VSEL0 = 8'h40;
    localparam logic [7:0] OFS_VSEL7 = 8'h5c;

    // Field positions
    localparam int SLP_MODE_A_BIT = 0;
    localparam int SLP_MODE_B_BIT = 1;
    localparam int SLP_GRP_A_LSB = 8;
    localparam int SLP_GRP_B_LSB = 16;
    localparam int GPO_SRC_LSB = 0;
    localparam int GPO_VAL_LSB = 4;
    localparam int GPO_PP_LSB = 8;
    localparam int STS_EN_LSB = 0;
    localparam int STS_RAIL_LSB = 8;
    localparam int STS_SLEEP_LSB = 16;
    localparam int STS_PG_LSB = 24;
    localparam int VSEL_SLEEP_LSB = 8;

    // Which enable inputs may act as sleep controls (third and sixth)
    localparam int SLP_IN_A = 2;
    localparam int SLP_IN_B = 5;

    // Values after reset
    localparam logic [N_RAIL-1:0] RST_ENMAP = 8'h00;
    localparam logic [31:0] RST_SLEEP_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_GPO_CFG = 32'h0000_0000;
    localparam logic [N_RAIL-1:0] RST_PGMASK = 8'h00;
    localparam logic [15:0] RST_VSEL = 16'h0000;
endpackage : ppcm_pkg

// file: hw/ppcm_debounce.sv
// Purpose: Two-stage synchroniser followed by a stability debouncer
// Assumes: Input may be asynchronous to clk_i
// Notes: Output changes only after the input holds a new level DEB_CYCLES clocks
`timescale 1ns/1ps
module ppcm_debounce #(
    parameter logic RST_LEVEL = 1'b0
) (
    input wire logic clk_i,      // System clock
    input wire logic rst_i,      // Async reset, active high
    input wire logic pin_i,      // Raw pin level
    output logic level_o         // Debounced level
);
    logic meta_r;
    logic sync_r;
    logic [ppcm_pkg::DEB_CNT_W-1:0] cnt_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_LEVEL;
            sync_r <= RST_LEVEL;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            level_o <= RST_LEVEL;
        end else if (sync_r == level_o) begin
            cnt_r <= '0;
        end else if (cnt_r == ppcm_pkg::DEB_CNT_W'(ppcm_pkg::DEB_CYCLES - 1)) begin
            cnt_r <= '0;
            level_o <= sync_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : ppcm_debounce

// file: hw/ppcm_top.sv
// Purpose: Control-pin logic: rail enables, sleep control, interrupt and GPO pins
// Assumes: Classic Wishbone slave, 32-bit data, single clock CLK_I
// Notes: Open-drain pins drive low when their OE_N output is low
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// R1 - High enable input turns its rail group on
// R2 - Sleep inputs low put chosen group asleep
// R3 - Sleeping rails use their sleep voltage code
// R4 - Interrupt pin pulls low while interrupt pending
// R5 - Outputs one to three: open-drain or push-pull
// R6 - Output source: power-good of rails, or bit
// R7 - Output four is always open-drain
// R8 - Inputs synchronised and debounced before use; only enable inputs are, power-good and interrupt level get one flop
module ppcm_top (
    input wire logic CLK_I,                          // System clock, 25 MHz
    input wire logic SYS_RST_I,                      // Async reset, active high
    input wire logic CYC_I,                          // Wishbone cycle
    input wire logic STB_I,                          // Wishbone strobe
    input wire logic WE_I,                           // Wishbone write enable
    input wire logic [7:0] ADR_I,                    // Wishbone byte address
    input wire logic [3:0] SEL_I,                    // Wishbone byte selects
    input wire logic [31:0] DAT_I,                   // Wishbone write data
    output logic [31:0] DAT_O,                       // Wishbone read data
    output logic ACK_O,                              // Wishbone acknowledge
    input wire logic [5:0] RAIL_GROUP_ENABLE_I,      // Enable pins 1..6
    input wire logic [7:0] RAIL_PG_I,                // Power-good per rail
    input wire logic IRQ_PENDING_I,                  // Interrupt pending level
    output logic [7:0] RAIL_EN_O,                    // Rail on request
    output logic [7:0] RAIL_SLEEP_O,                 // Rail in sleep state
    output logic [63:0] RAIL_VSEL_O,                 // Voltage code per rail
    output logic INTERRUPT_OUT_N_O,                  // Interrupt pin drive value
    output logic INTERRUPT_OUT_N_OE_N_O,             // Interrupt pin enable, low drives
    output logic [3:0] GENERAL_OUTPUT_O,             // Output pins drive value
    output logic [3:0] GENERAL_OUTPUT_OE_N_O         // Output pins enable, low drives
);
    localparam int NE = ppcm_pkg::N_EN;
    localparam int NR = ppcm_pkg::N_RAIL;
    localparam int NG = ppcm_pkg::N_GPO;
    localparam int VW = ppcm_pkg::VSEL_W;

    logic [NE-1:0] en_db;
    logic [NR-1:0] enmap_r [NE];
    logic [31:0] sleep_cfg_r;
    logic [31:0] gpo_cfg_r;
    logic [NR-1:0] pgmask_r [NG];
    logic [15:0] vsel_r [NR];
    logic ack_r;
    logic [31:0] rdat_r;
    logic req;
    logic wr_stb;
    logic [31:0] rdat_nxt;
    logic [NR-1:0] rail_en_nxt;
    logic [NR-1:0] rail_sleep_nxt;
    logic [NG-1:0] gpo_level;
    logic slp_mode_a;
    logic slp_mode_b;
    logic [NR-1:0] slp_grp_a;
    logic [NR-1:0] slp_grp_b;
    logic [NR-1:0] pg_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Enable pins are synchronised and filtered before any rail acts on them
    for (genvar g = 0; g < NE; g++) begin : g_deb
        ppcm_debounce #(
            .RST_LEVEL(1'b0)
        ) u_deb (
            .clk_i(CLK_I),
            .rst_i(SYS_RST_I),
            .pin_i(RAIL_GROUP_ENABLE_I[g]),
            .level_o(en_db[g])
        ); // R8
    end

    // Bus slave: one wait state, ack drops the cycle after it was given
    assign req = CYC_I & STB_I;
    assign wr_stb = req & WE_I & ~ack_r;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read data stands only in the acknowledge cycle
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rdat_r <= 32'h0000_0000;
        end else begin
            rdat_r <= (req & ~ack_r & ~WE_I) ? rdat_nxt : 32'h0000_0000;
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = rdat_r;

    // Address decode; every register sits on a word boundary
    logic adr_word;
    logic hit_enmap;
    logic hit_sleep;
    logic hit_gpo;
    logic hit_pgmask;
    logic hit_status;
    logic hit_vsel;

    assign adr_word = (ADR_I[1:0] == 2'b00);
    assign hit_enmap = adr_word && ADR_I >= ppcm_pkg::OFS_ENMAP0
                       && ADR_I <= ppcm_pkg::OFS_ENMAP5;
    assign hit_sleep = (ADR_I == ppcm_pkg::OFS_SLEEP_CFG);
    assign hit_gpo = (ADR_I == ppcm_pkg::OFS_GPO_CFG);
    assign hit_pgmask = adr_word && ADR_I >= ppcm_pkg::OFS_GPO_PGMASK0
                        && ADR_I <= ppcm_pkg::OFS_GPO_PGMASK3;
    assign hit_status = (ADR_I == ppcm_pkg::OFS_STATUS);
    assign hit_vsel = adr_word && ADR_I >= ppcm_pkg::OFS_VSEL0
                      && ADR_I <= ppcm_pkg::OFS_VSEL7;

    // Enable-group maps
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NE; i++) begin
                enmap_r[i] <= ppcm_pkg::RST_ENMAP;
            end
        end else if (wr_stb && hit_enmap) begin
            enmap_r[ADR_I[4:2]] <= NR'(merge({24'h000000, enmap_r[ADR_I[4:2]]}, DAT_I, SEL_I));
        end
    end

    // Sleep and output configuration
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sleep_cfg_r <= ppcm_pkg::RST_SLEEP_CFG;
            gpo_cfg_r <= ppcm_pkg::RST_GPO_CFG;
        end else if (wr_stb && hit_sleep) begin
            sleep_cfg_r <= merge(sleep_cfg_r, DAT_I, SEL_I) & 32'h00ff_ff03;
        end else if (wr_stb && hit_gpo) begin
            gpo_cfg_r <= merge(gpo_cfg_r, DAT_I, SEL_I) & 32'h0000_07ff;
        end
    end

    // Power-good masks for the general outputs
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NG; i++) begin
                pgmask_r[i] <= ppcm_pkg::RST_PGMASK;
            end
        end else if (wr_stb && hit_pgmask) begin
            pgmask_r[ADR_I[3:2]] <= NR'(merge({24'h000000, pgmask_r[ADR_I[3:2]]}, DAT_I, SEL_I));
        end
    end

    // Normal and sleep voltage codes per rail
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < NR; i++) begin
                vsel_r[i] <= ppcm_pkg::RST_VSEL;
            end
        end else if (wr_stb && hit_vsel) begin
            vsel_r[ADR_I[4:2]] <= 16'(merge({16'h0000, vsel_r[ADR_I[4:2]]}, DAT_I, SEL_I));
        end
    end

    // Read mux; unmapped addresses read zero and ignore writes
    always_comb begin
        rdat_nxt = 32'h0000_0000;
        if (ADR_I[1:0] == 2'b00) begin
            if (ADR_I <= ppcm_pkg::OFS_ENMAP5) begin
                rdat_nxt = {24'h000000, enmap_r[ADR_I[4:2]]};
            end else if (hit_sleep) begin
                rdat_nxt = sleep_cfg_r;
            end else if (hit_gpo) begin
                rdat_nxt = gpo_cfg_r;
            end else if (ADR_I >= ppcm_pkg::OFS_GPO_PGMASK0
                         && ADR_I <= ppcm_pkg::OFS_GPO_PGMASK3) begin
                rdat_nxt = {24'h000000, pgmask_r[ADR_I[3:2]]};
            end else if (hit_status) begin
                rdat_nxt[ppcm_pkg::STS_EN_LSB +: NE] = en_db;
                rdat_nxt[ppcm_pkg::STS_RAIL_LSB +: NR] = RAIL_EN_O;
                rdat_nxt[ppcm_pkg::STS_SLEEP_LSB +: NR] = RAIL_SLEEP_O;
                rdat_nxt[ppcm_pkg::STS_PG_LSB +: NR] = pg_r;
            end else if (ADR_I >= ppcm_pkg::OFS_VSEL0 && ADR_I <= ppcm_pkg::OFS_VSEL7) begin
                rdat_nxt = {16'h0000, vsel_r[ADR_I[4:2]]};
            end
        end
    end

    assign slp_mode_a = sleep_cfg_r[ppcm_pkg::SLP_MODE_A_BIT];
    assign slp_mode_b = sleep_cfg_r[ppcm_pkg::SLP_MODE_B_BIT];
    assign slp_grp_a = sleep_cfg_r[ppcm_pkg::SLP_GRP_A_LSB +: NR];
    assign slp_grp_b = sleep_cfg_r[ppcm_pkg::SLP_GRP_B_LSB +: NR];

    // Rail on/off from enable inputs; a pin in sleep mode no longer enables
    always_comb begin
        rail_en_nxt = '0;
        for (int i = 0; i < NE; i++) begin
            if (en_db[i] && !(i == ppcm_pkg::SLP_IN_A && slp_mode_a)
                && !(i == ppcm_pkg::SLP_IN_B && slp_mode_b)) begin
                rail_en_nxt = rail_en_nxt | enmap_r[i]; // R1
            end
        end
    end

    // Low on a sleep-mode pin puts its chosen group to sleep
    always_comb begin
        rail_sleep_nxt = '0;
        if (slp_mode_a && !en_db[ppcm_pkg::SLP_IN_A]) begin
            rail_sleep_nxt = rail_sleep_nxt | slp_grp_a; // R2
        end
        if (slp_mode_b && !en_db[ppcm_pkg::SLP_IN_B]) begin
            rail_sleep_nxt = rail_sleep_nxt | slp_grp_b; // R2
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            RAIL_EN_O <= '0;
            RAIL_SLEEP_O <= '0;
        end else begin
            RAIL_EN_O <= rail_en_nxt; // R1
            RAIL_SLEEP_O <= rail_sleep_nxt; // R2
        end
    end

    // Voltage code follows the rail's state
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            RAIL_VSEL_O <= '0;
        end else begin
            for (int i = 0; i < NR; i++) begin
                RAIL_VSEL_O[i*VW +: VW] <= rail_sleep_nxt[i]
                    ? vsel_r[i][ppcm_pkg::VSEL_SLEEP_LSB +: VW]
                    : vsel_r[i][VW-1:0]; // R3
            end
        end
    end

    // Interrupt pin: open drain, pulled low while pending
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            INTERRUPT_OUT_N_O <= 1'b0;
            INTERRUPT_OUT_N_OE_N_O <= 1'b1;
        end else begin
            INTERRUPT_OUT_N_O <= 1'b0;
            INTERRUPT_OUT_N_OE_N_O <= ~IRQ_PENDING_I; // R4
        end
    end

    // Power-good sampled into the clock domain
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pg_r <= '0;
        end else begin
            pg_r <= RAIL_PG_I;
        end
    end

    // Output configuration fields
    logic [NG-1:0] gpo_src;
    logic [NG-1:0] gpo_val;
    logic [NG-2:0] gpo_pp;

    assign gpo_src = gpo_cfg_r[ppcm_pkg::GPO_SRC_LSB +: NG];
    assign gpo_val = gpo_cfg_r[ppcm_pkg::GPO_VAL_LSB +: NG];
    assign gpo_pp = gpo_cfg_r[ppcm_pkg::GPO_PP_LSB +: NG - 1];

    // Output level: all selected rails good, or the software bit
    always_comb begin
        for (int i = 0; i < NG; i++) begin
            gpo_level[i] = gpo_src[i]
                ? gpo_val[i]
                : &(pg_r | ~pgmask_r[i]); // R6
        end
    end

    // Stage type: push-pull drives both levels, open drain only pulls low
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            GENERAL_OUTPUT_O <= '0;
            GENERAL_OUTPUT_OE_N_O <= '1;
        end else begin
            for (int i = 0; i < NG - 1; i++) begin
                if (gpo_pp[i]) begin
                    GENERAL_OUTPUT_O[i] <= gpo_level[i]; // R5
                    GENERAL_OUTPUT_OE_N_O[i] <= 1'b0; // R5
                end else begin
                    GENERAL_OUTPUT_O[i] <= 1'b0;
                    GENERAL_OUTPUT_OE_N_O[i] <= gpo_level[i]; // R5
                end
            end
            GENERAL_OUTPUT_O[NG-1] <= 1'b0; // R7
            GENERAL_OUTPUT_OE_N_O[NG-1] <= gpo_level[NG-1]; // R7
        end
    end
endmodule : ppcm_top

// file: tb/ppcm_top_asserts.sv
// Purpose: Port-level checker for the control-pin block
// Assumes: Single clock domain, async active-high reset
// Notes: Attached to the top module by bind
`timescale 1ns/1ps
module ppcm_top_asserts (
    input wire logic CLK_I, // Clock
    input wire logic SYS_RST_I, // Reset
    input wire logic CYC_I, // Cycle
    input wire logic STB_I, // Strobe
    input wire logic WE_I, // Write
    input wire logic [7:0] ADR_I, // Address
    input wire logic [3:0] SEL_I, // Lanes
    input wire logic [31:0] DAT_I, // Write data
    input wire logic [31:0] DAT_O, // Read data
    input wire logic ACK_O, // Acknowledge
    input wire logic [5:0] RAIL_GROUP_ENABLE_I, // Enable pins
    input wire logic [7:0] RAIL_PG_I, // Power-good
    input wire logic IRQ_PENDING_I, // Interrupt level
    input wire logic [7:0] RAIL_EN_O, // Rail on
    input wire logic [7:0] RAIL_SLEEP_O, // Rail asleep
    input wire logic [63:0] RAIL_VSEL_O, // Voltage codes
    input wire logic INTERRUPT_OUT_N_O, // Interrupt value
    input wire logic INTERRUPT_OUT_N_OE_N_O, // Interrupt enable
    input wire logic [3:0] GENERAL_OUTPUT_O, // Output values
    input wire logic [3:0] GENERAL_OUTPUT_OE_N_O // Output enables
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_req; CYC_I && STB_I && !ACK_O; endsequence
    sequence s_ack_once; ACK_O ##1 !ACK_O; endsequence
    property p_ack_wait; s_req |=> s_ack_once; endproperty
    property p_ack_cause; ACK_O |-> $past(CYC_I) && $past(STB_I); endproperty
    property p_dat_idle; !ACK_O |-> DAT_O == 32'h0; endproperty
    property p_irq_val; INTERRUPT_OUT_N_O == 1'b0; endproperty
    property p_irq_set; IRQ_PENDING_I |=> !INTERRUPT_OUT_N_OE_N_O; endproperty
    property p_irq_clr; !IRQ_PENDING_I |=> INTERRUPT_OUT_N_OE_N_O; endproperty
    property p_general_output_4; GENERAL_OUTPUT_O[3] == 1'b0; endproperty
    property p_od; (GENERAL_OUTPUT_O & GENERAL_OUTPUT_OE_N_O) == 4'h0; endproperty
    property p_deb;
        $changed(RAIL_GROUP_ENABLE_I) |=>
            (($stable(RAIL_EN_O) && $stable(RAIL_SLEEP_O)) || CYC_I || $past(CYC_I))[*8];
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("ack missing or too long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_irq_val: assert property (p_irq_val) else $error("interrupt pin driven high");
    a_irq_set: assert property (p_irq_set) else $error("interrupt not pulled low");
    a_irq_clr: assert property (p_irq_clr) else $error("interrupt not released");
    a_general_output_4: assert property (p_general_output_4) else $error("output four driven high");
    a_od: assert property (p_od) else $error("released pin carries high value");
    a_deb: assert property (p_deb) else $error("rails moved before debounce");
endmodule : ppcm_top_asserts

bind ppcm_top ppcm_top_asserts u_chk (.CLK_I, .SYS_RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I,
    .SEL_I, .DAT_I, .DAT_O, .ACK_O, .RAIL_GROUP_ENABLE_I, .RAIL_PG_I, .IRQ_PENDING_I,
    .RAIL_EN_O, .RAIL_SLEEP_O, .RAIL_VSEL_O, .INTERRUPT_OUT_N_O, .INTERRUPT_OUT_N_OE_N_O,
    .GENERAL_OUTPUT_O, .GENERAL_OUTPUT_OE_N_O);

// file: tb/ppcm_host_model.sv
// Purpose: Host side driving control pins and reading output pins
// Assumes: Pull-ups on every open-drain line
// Notes: Pin changes land just after a rising edge
`timescale 1ns/1ps
module ppcm_host_model (
    input wire logic clk_i, // Clock
    output logic [5:0] en_o, // Enable pins
    output logic [7:0] pg_o, // Power-good levels
    output logic irq_o, // Interrupt pending
    input wire logic irq_val_i, // Interrupt value
    input wire logic irq_oe_n_i, // Interrupt enable
    input wire logic [3:0] gpo_val_i, // Output values
    input wire logic [3:0] gpo_oe_n_i, // Output enables
    output logic irq_pin_o, // Interrupt line level
    output logic [3:0] gpo_pin_o // Output line levels
);
    initial begin
        en_o = 6'h00;
        pg_o = 8'h00;
        irq_o = 1'b0;
    end
    // Released lines float high through the pull-up
    assign irq_pin_o = irq_oe_n_i ? 1'b1 : irq_val_i;
    assign gpo_pin_o = (gpo_val_i & ~gpo_oe_n_i) | gpo_oe_n_i;
    task automatic set_pins(input logic [5:0] e, input logic [7:0] p, input logic q);
        @(posedge clk_i);
        en_o <= e;
        pg_o <= p;
        irq_o <= q;
    endtask : set_pins
endmodule : ppcm_host_model

// file: tb/ppcm_top_tb.sv
// Purpose: Self-checking bench for the control-pin block
// Assumes: Wishbone answer comes within a few cycles
// Notes: Enable-pin checks wait past the debounce span, except the glitch-held check after 10 cycles
`timescale 1ns/1ps
module ppcm_top_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ipin, iv, ioe;
    logic [7:0] adr = 8'h00, ren, rsl, pg;
    logic [3:0] sel = 4'h0, gv, goe, gpin;
    logic [3:0] lanes = 4'hf;
    logic [31:0] dat = 32'h0, dato, q;
    logic [63:0] vsel;
    logic [5:0] en;
    logic irq;
    int failures = 0, check_count = 0;
    always #20 clk = ~clk;
    ppcm_top dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack),
        .RAIL_GROUP_ENABLE_I(en), .RAIL_PG_I(pg), .IRQ_PENDING_I(irq), .RAIL_EN_O(ren),
        .RAIL_SLEEP_O(rsl), .RAIL_VSEL_O(vsel), .INTERRUPT_OUT_N_O(iv),
        .INTERRUPT_OUT_N_OE_N_O(ioe), .GENERAL_OUTPUT_O(gv), .GENERAL_OUTPUT_OE_N_O(goe));
    ppcm_host_model u_host (.clk_i(clk), .en_o(en), .pg_o(pg), .irq_o(irq),
        .irq_val_i(iv), .irq_oe_n_i(ioe), .gpo_val_i(gv), .gpo_oe_n_i(goe),
        .irq_pin_o(ipin), .gpo_pin_o(gpin));
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, lanes, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dato;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic pins(input logic [5:0] e, input logic [7:0] p, input logic i, input int n);
        u_host.set_pins(e, p, i);
        repeat (n) @(posedge clk);
    endtask : pins
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        check("reset gpo oe", goe, 4'hf);
        check("reset irq pin", ipin, 1'b1);
        wb(1'b0, ppcm_pkg::OFS_STATUS, 32'h0);
        check("reset status", q, 32'h0);
        wb(1'b0, 8'h34, 32'h0);
        check("unmapped read", q, 32'h0);
        wb(1'b1, ppcm_pkg::OFS_ENMAP0, 32'h05);
        wb(1'b1, 8'h04, 32'h30);
        pins(6'h03, 8'h00, 1'b0, 40);
        check("rails on", ren, 8'h35);
        wb(1'b0, ppcm_pkg::OFS_STATUS, 32'h0);
        check("status pins", q[15:0], 16'h3503);
        wb(1'b0, 8'h04, 32'h0);
        check("map readback", q, 32'h0000_0030);
        pins(6'h00, 8'h00, 1'b0, 10);
        check("glitch held", ren, 8'h35);
        pins(6'h03, 8'h00, 1'b0, 40);
        check("glitch ignored", ren, 8'h35);
        pins(6'h04, 8'h00, 1'b0, 40);
        check("rails off", ren, 8'h00);
        wb(1'b1, 8'h48, 32'h3311);
        wb(1'b1, ppcm_pkg::OFS_SLEEP_CFG, 32'h0080_0c03);
        repeat (3) @(posedge clk);
        check("sleep b low", rsl, 8'h80);
        check("normal code", vsel[23:16], 8'h11);
        wb(1'b0, ppcm_pkg::OFS_SLEEP_CFG, 32'h0);
        check("sleep cfg readback", q, 32'h0080_0c03);
        wb(1'b0, 8'h48, 32'h0);
        check("code readback", q, 32'h0000_3311);
        pins(6'h20, 8'h00, 1'b0, 40);
        check("sleep a low", rsl, 8'h0c);
        check("sleep code", vsel[23:16], 8'h33);
        check("sleep pin no enable", ren, 8'h00);
        pins(6'h24, 8'h00, 1'b1, 40);
        check("sleep exit", rsl, 8'h00);
        check("code back", vsel[23:16], 8'h11);
        check("irq low", ipin, 1'b0);
        wb(1'b1, 8'h24, 32'h03);
        wb(1'b1, ppcm_pkg::OFS_GPO_CFG, 32'h0000_0399);
        pins(6'h24, 8'h01, 1'b0, 4);
        check("irq released", ipin, 1'b1);
        check("gpo oe a", goe, 4'b1100);
        check("gpo pin a", gpin, 4'b1101);
        pins(6'h24, 8'h03, 1'b0, 4);
        check("gpo pin b", gpin, 4'b1111);
        wb(1'b0, ppcm_pkg::OFS_STATUS, 32'h0);
        check("status pg", q, 32'h0300_0024);
        wb(1'b1, ppcm_pkg::OFS_GPO_CFG, 32'h0000_0309);
        repeat (3) @(posedge clk);
        check("gpo oe c", goe, 4'b0100);
        check("gpo pin c", gpin, 4'b0110);
        lanes = 4'h2;
        wb(1'b1, 8'h48, 32'h0000_5566);
        lanes = 4'hf;
        wb(1'b1, 8'h49, 32'h0000_7777);
        wb(1'b0, 8'h48, 32'h0);
        check("lane write", q, 32'h0000_5511);
        report_and_stop();
    end
endmodule : ppcm_top_tb
